// [logic/thermal_oc_pkg.sv]
// Constants, field layouts and carrier types for the thermal overcurrent
// timing element. Assumes one 25 MHz clock shared with the front end.
package thermal_oc_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_PERIOD_US = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PICKUP = 8'h04;
  localparam logic [7:0] OFS_TCHAR = 8'h08;
  localparam logic [7:0] OFS_TRESET = 8'h0c;
  localparam logic [7:0] OFS_VTSEC = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  localparam int CB_CT5A = 0;
  localparam int CB_GROUND = 1;
  localparam int CB_CURVE = 2;
  localparam int CB_RMODE = 4;
  localparam int CB_VR_EN = 6;
  localparam int CB_MODE_PG = 7;
  localparam int CB_CONN_PG = 8;
  localparam int CB_NEGSEQ = 9;
  localparam int CB_VTS_EN = 10;
  localparam int CTRL_W = 11;

  typedef enum logic [1:0] {
    CURVE_FLAT = 2'h0,
    CURVE_LINEAR = 2'h1,
    CURVE_SQUARE = 2'h3,
    CURVE_FOURTH = 2'h2
  } curve_t;

  typedef enum logic [1:0] {
    RMODE_CHAR = 2'h0,
    RMODE_FIXED = 2'h1,
    RMODE_INST = 2'h3
  } rmode_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TIMING = 2'h1,
    ST_TRIPPED = 2'h3,
    ST_RESETTING = 2'h2
  } state_t;

  localparam logic [6:0] K_PHASE = 7'h03;
  localparam logic [6:0] K_GROUND = 7'h01;
  localparam int M_LINEAR = 1;
  localparam int M_SQUARE = 2;
  localparam logic [2:0] TRIP_FACTOR = 3'h5;
  localparam logic [5:0] RESET_FACTOR = 6'h2d;

  localparam int RATIO_FRAC = 10;
  localparam int ACC_FRAC = 40;
  localparam int ACC_W = 72;
  localparam logic [71:0] ACC_ONE = 72'h1 << ACC_FRAC;
  localparam logic [15:0] RATIO_MAX = 16'ha000;
  localparam logic [15:0] PICKUP_MIN = 16'h0015;
  localparam logic [18:0] SCALE_1A = 19'h40000;
  localparam logic [18:0] SCALE_5A = 19'h0cccd;

  localparam logic [10:0] PCT_MIN = 11'h100;
  localparam logic [10:0] PCT_FULL = 11'h400;
  localparam int VMIN_SHIFT = 2;
  localparam logic [26:0] RECIP_ONE = 27'h4000000;
  localparam logic [4:0] RECIP_STEPS = 5'h1b;
  localparam logic [16:0] INV_SQRT3 = 17'h093cd;
  localparam logic [16:0] SQRT3_HALF = 17'h0ddb4;
  localparam logic [16:0] ONE_THIRD = 17'h05555;

  localparam logic [15:0] PICKUP_RST = 16'h0400;
  localparam logic [15:0] TCHAR_RST = 16'h0064;
  localparam logic [15:0] TRESET_RST = 16'h0000;
  localparam logic [15:0] VTSEC_RST = 16'h03e8;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [2:0][15:0] mag;
    logic [2:0][15:0] re;
    logic [2:0][15:0] im;
    logic [2:0][15:0] v_pp;
    logic [2:0][15:0] v_pg;
  } meas_t;
endpackage

// [logic/thermal_curve_overcurrent_timing.sv]
// Thermal curve overcurrent element with voltage restraint and
// negative-sequence operation. Assumes measurements arrive on CLK_I.
//
// Design decisions made here: strobed register access and the address map.
module thermal_curve_overcurrent_timing
  import thermal_oc_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RESET_I,
  // Register port.
  input wire reg_req_t REG_REQ_I,
  output logic [31:0] REG_RDATA_O,
  // Measurements from the front end.
  input wire meas_t MEAS_I,
  // Voltage supervision breaker pin.
  input wire logic MCB_TRIP_I,
  // Element outputs.
  output logic TRIP_O,
  output logic PICKUP_O
);

  function automatic logic [15:0] to_ratio(
    input logic [15:0] amps,
    input logic ct5
  );
    logic [34:0] p;
    p = amps * (ct5 ? SCALE_5A : SCALE_1A);
    if (p[34:16] > {3'h0, RATIO_MAX}) begin
      return RATIO_MAX;
    end
    return p[31:16];
  endfunction

  function automatic logic signed [18:0] mulk(
    input logic signed [18:0] a,
    input logic [16:0] k
  );
    logic signed [36:0] p;
    p = a * $signed({1'b0, k});
    return p[34:16];
  endfunction

  function automatic logic [18:0] absv(input logic signed [18:0] a);
    return a[18] ? 19'(-a) : a;
  endfunction

  logic [31:0] tick_cnt;
  logic tick;
  logic mcb_meta;
  logic mcb_sync;
  logic [CTRL_W-1:0] ctrl;
  logic [15:0] pickup;
  logic [15:0] tchar;
  logic [15:0] treset;
  logic [15:0] vtsec;
  logic ct5;
  logic negseq;
  logic vr_act;
  logic mode_pg;
  logic conn_pg;
  logic blocked;
  curve_t curve;
  rmode_t rmode;
  logic [32:0] vn_prod;
  logic [15:0] vn;
  logic [26:0] div_dvd;
  logic [26:0] div_quo;
  logic [26:0] recip;
  logic [16:0] div_rem;
  logic [16:0] div_trial;
  logic div_bit;
  logic [4:0] div_cnt;
  logic [15:0] div_den;
  logic [2:0][15:0] ratio;
  logic [2:0][15:0] eff_pick;
  logic [2:0] above_ph;
  logic signed [18:0] sx [3];
  logic signed [18:0] sy [3];
  logic signed [18:0] ns_re;
  logic signed [18:0] ns_im;
  logic [18:0] ns_a;
  logic [18:0] ns_b;
  logic [18:0] ns_sum;
  logic [15:0] ns_mag;
  logic [15:0] i2_ratio;
  logic [15:0] ph_max;
  logic [15:0] r_meas;
  logic above;
  logic [31:0] r2;
  logic [63:0] r4;
  logic [6:0] kk;
  logic [6:0] kpow;
  logic [71:0] inc;
  logic [25:0] base;
  logic [71:0] thr;
  logic [23:0] rtarget;
  logic [23:0] next_rcnt;
  logic [71:0] next_acc;
  state_t state;
  logic [71:0] acc;
  logic [23:0] rcnt;

  // Fixed-rate sample tick.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == 32'(TICK_LEN - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
      tick <= 1'b0;
    end
  end

  // Breaker pin synchroniser.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mcb_meta <= 1'b0;
      mcb_sync <= 1'b0;
    end else begin
      mcb_meta <= MCB_TRIP_I;
      mcb_sync <= mcb_meta;
    end
  end

  // Setting registers.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl <= '0;
      pickup <= PICKUP_RST;
      tchar <= TCHAR_RST;
      treset <= TRESET_RST;
      vtsec <= VTSEC_RST;
    end else if (REG_REQ_I.wr) begin
      if (REG_REQ_I.addr == OFS_CTRL) begin
        ctrl <= REG_REQ_I.wdata[CTRL_W-1:0];
      end else if (REG_REQ_I.addr == OFS_PICKUP) begin
        pickup <= (REG_REQ_I.wdata[15:0] < PICKUP_MIN) ?
          PICKUP_MIN : REG_REQ_I.wdata[15:0];
      end else if (REG_REQ_I.addr == OFS_TCHAR) begin
        tchar <= REG_REQ_I.wdata[15:0];
      end else if (REG_REQ_I.addr == OFS_TRESET) begin
        treset <= REG_REQ_I.wdata[15:0];
      end else if (REG_REQ_I.addr == OFS_VTSEC) begin
        vtsec <= REG_REQ_I.wdata[15:0];
      end
    end
  end

  a_pickup_floor: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    REG_REQ_I.wr && REG_REQ_I.addr == OFS_PICKUP &&
    REG_REQ_I.wdata[15:0] < PICKUP_MIN |=> pickup == PICKUP_MIN)
    else $error("Pickup below floor was stored.");

  assign ct5 = ctrl[CB_CT5A];
  assign curve = curve_t'(ctrl[CB_CURVE +: 2]);
  assign rmode = rmode_t'(ctrl[CB_RMODE +: 2]);
  assign negseq = ctrl[CB_NEGSEQ];
  assign conn_pg = ctrl[CB_CONN_PG];
  assign mode_pg = ctrl[CB_MODE_PG] & conn_pg;
  assign vr_act = ctrl[CB_VR_EN] & ~negseq;
  assign blocked = vr_act & ctrl[CB_VTS_EN] & mcb_sync;

  // Reference voltage.
  assign vn_prod = vtsec * INV_SQRT3;
  assign vn = mode_pg ? vn_prod[31:16] : vtsec;

  a_refv_select: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !(conn_pg && ctrl[CB_MODE_PG]) |-> vn == vtsec)
    else $error("Reference voltage not the secondary rating.");

  // Free-running reciprocal of the reference voltage.
  assign div_trial = {div_rem[15:0], div_dvd[26]};
  assign div_bit = div_trial >= {1'b0, div_den};
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      div_dvd <= '0;
      div_quo <= '0;
      div_rem <= '0;
      div_cnt <= '0;
      div_den <= '0;
      recip <= '1;
    end else if (div_cnt == 5'h0) begin
      div_den <= vn;
      div_dvd <= RECIP_ONE;
      div_rem <= '0;
      div_quo <= '0;
      div_cnt <= RECIP_STEPS;
    end else begin
      div_dvd <= div_dvd << 1;
      div_rem <= div_bit ? div_trial - {1'b0, div_den} : div_trial;
      div_quo <= {div_quo[25:0], div_bit};
      div_cnt <= div_cnt - 5'h1;
      if (div_cnt == 5'h1) begin
        recip <= (div_den == 16'h0) ? '1 : {div_quo[25:0], div_bit};
      end
    end
  end

  // Per-phase restraint and pickup.
  for (genvar i = 0; i < 3; i++) begin : g_ph
    logic [15:0] v;
    logic [15:0] vmin;
    logic [42:0] slope;
    logic [10:0] pct;
    logic [26:0] eff_prod;
    assign v = mode_pg ? MEAS_I.v_pg[i] : MEAS_I.v_pp[i];
    assign vmin = vn >> VMIN_SHIFT;
    assign slope = (v - vmin) * recip;
    always_comb begin
      if (v <= vmin) begin
        pct = PCT_MIN;
      end else if (v >= vn) begin
        pct = PCT_FULL;
      end else begin
        pct = PCT_MIN + slope[26:16];
      end
    end
    assign eff_prod = pickup * (vr_act ? pct : PCT_FULL);
    assign eff_pick[i] = (eff_prod[25:10] < PICKUP_MIN) ?
      PICKUP_MIN : eff_prod[25:10];
    assign ratio[i] = to_ratio(MEAS_I.mag[i], ct5);
    assign above_ph[i] = ratio[i] > eff_pick[i];
    assign sx[i] = 19'(signed'(MEAS_I.re[i]));
    assign sy[i] = 19'(signed'(MEAS_I.im[i]));

    a_eff_floor: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      (eff_pick[i] >= PICKUP_MIN) and
      (v >= vn && vn > vmin |-> pct == PCT_FULL))
      else $error("Effective pickup out of range.");
  end

  // Negative-sequence current and its magnitude.
  assign ns_re = mulk(sx[0] - ((sx[1] + sx[2]) >>> 1) +
    mulk(sy[1] - sy[2], SQRT3_HALF), ONE_THIRD);
  assign ns_im = mulk(sy[0] - ((sy[1] + sy[2]) >>> 1) +
    mulk(sx[2] - sx[1], SQRT3_HALF), ONE_THIRD);
  assign ns_a = (absv(ns_re) > absv(ns_im)) ? absv(ns_re) : absv(ns_im);
  assign ns_b = (absv(ns_re) > absv(ns_im)) ? absv(ns_im) : absv(ns_re);
  assign ns_sum = ns_a + ((ns_b + (ns_b << 1)) >> 3);
  assign ns_mag = (ns_sum[18:16] != 3'h0) ? 16'hffff : ns_sum[15:0];
  assign i2_ratio = to_ratio(ns_mag, ct5);

  always_comb begin
    ph_max = ratio[0];
    for (int j = 1; j < 3; j++) begin
      if (ratio[j] > ph_max) begin
        ph_max = ratio[j];
      end
    end
  end

  assign r_meas = negseq ? i2_ratio : ph_max;
  assign above = negseq ? (i2_ratio > pickup) : |above_ph;

  // Curve increment per tick and the delay it is held against.
  assign r2 = r_meas * r_meas;
  assign r4 = r2 * r2;
  assign kk = ctrl[CB_GROUND] ? K_GROUND : K_PHASE;
  always_comb begin
    case (curve)
      CURVE_LINEAR: begin
        kpow = kk;
        inc = 72'(r_meas) << (ACC_FRAC - M_LINEAR * RATIO_FRAC);
      end
      CURVE_SQUARE: begin
        kpow = 7'(kk * kk);
        inc = 72'(r2) << (ACC_FRAC - M_SQUARE * RATIO_FRAC);
      end
      CURVE_FOURTH: begin
        kpow = 7'(kk * kk * kk * kk);
        inc = 72'(r4);
      end
      default: begin
        kpow = 7'h01;
        inc = ACC_ONE;
      end
    endcase
  end
  assign base = tchar * kpow * TRIP_FACTOR;
  assign thr = 72'(base) << ACC_FRAC;
  assign rtarget = (rmode == RMODE_FIXED) ?
    24'(treset) : tchar * RESET_FACTOR;
  assign next_rcnt = rcnt + 24'h1;
  assign next_acc = acc + inc;

  // Element state, elapsed time and reset timer.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state <= ST_IDLE;
      acc <= '0;
      rcnt <= '0;
    end else if (blocked) begin
      state <= ST_IDLE;
      acc <= '0;
      rcnt <= '0;
    end else if (tick) begin
      if (above) begin
        rcnt <= '0;
        if (next_acc >= thr) begin
          acc <= thr;
          state <= ST_TRIPPED;
        end else begin
          acc <= next_acc;
          state <= ST_TIMING;
        end
      end else begin
        case (state)
          ST_IDLE: begin
            acc <= '0;
          end
          default: begin
            if (rmode == RMODE_INST || next_rcnt >= rtarget) begin
              acc <= '0;
              rcnt <= '0;
              state <= ST_IDLE;
            end else begin
              rcnt <= next_rcnt;
              state <= ST_RESETTING;
            end
          end
        endcase
      end
    end
  end

  a_acc_steady: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !tick && !blocked |=> $stable(acc))
    else $error("Elapsed time moved without a tick.");

  a_flat_step: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    tick && above && !blocked && curve == CURVE_FLAT &&
    next_acc < thr |=> acc == $past(acc) + ACC_ONE)
    else $error("Flat curve step is not one tick.");

  a_trip_reached: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    tick && above && !blocked && next_acc >= thr |=>
    state == ST_TRIPPED ##1 TRIP_O)
    else $error("Trip not raised when delay reached.");

  a_inst_reset: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    tick && !above && !blocked && rmode == RMODE_INST |=>
    acc == '0 && state == ST_IDLE)
    else $error("Instant reset did not clear time.");

  a_block_stops: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    blocked |=> !TRIP_O && acc == '0)
    else $error("Blocked element still timing.");

  // Registered element outputs.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      TRIP_O <= 1'b0;
      PICKUP_O <= 1'b0;
    end else begin
      TRIP_O <= (state == ST_TRIPPED) && !blocked;
      PICKUP_O <= above && !blocked;
    end
  end

  // Read port, data valid the cycle after the strobe.
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      REG_RDATA_O <= '0;
    end else if (REG_REQ_I.rd) begin
      if (REG_REQ_I.addr == OFS_CTRL) begin
        REG_RDATA_O <= 32'(ctrl);
      end else if (REG_REQ_I.addr == OFS_PICKUP) begin
        REG_RDATA_O <= 32'(pickup);
      end else if (REG_REQ_I.addr == OFS_TCHAR) begin
        REG_RDATA_O <= 32'(tchar);
      end else if (REG_REQ_I.addr == OFS_TRESET) begin
        REG_RDATA_O <= 32'(treset);
      end else if (REG_REQ_I.addr == OFS_VTSEC) begin
        REG_RDATA_O <= 32'(vtsec);
      end else if (REG_REQ_I.addr == OFS_STATUS) begin
        REG_RDATA_O <= 32'({blocked, above, TRIP_O, state});
      end else begin
        REG_RDATA_O <= '0;
      end
    end else begin
      REG_RDATA_O <= '0;
    end
  end

endmodule

// [dv/meas_front_end.sv]
// Behavioural front end that turns commanded amps and volts into phasors.
// Assumes the element's clock; every output changes just after an edge.
module meas_front_end
  import thermal_oc_pkg::*;
(
  // Clock.
  input wire logic clk_i,
  // Commanded quantities.
  input wire logic [15:0] amps_i,
  input wire logic neg_i,
  input wire logic [15:0] vpp_i,
  input wire logic [15:0] vpg_i,
  // Measurement bus.
  output meas_t meas_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int half;
  int side;
  always_comb begin
    half = int'(amps_i) / 2;
    side = (int'(amps_i) * 56756) / 65536;
  end
  // Phases one and two swap their angle for a negative-sequence set.
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < 3; p++) begin
      meas_o.mag[p] <= amps_i;
      meas_o.v_pp[p] <= vpp_i;
      meas_o.v_pg[p] <= vpg_i;
    end
    meas_o.re[0] <= amps_i;
    meas_o.re[1] <= 16'(-half);
    meas_o.re[2] <= 16'(-half);
    meas_o.im[0] <= 16'h0;
    meas_o.im[1] <= neg_i ? 16'(side) : 16'(-side);
    meas_o.im[2] <= neg_i ? 16'(-side) : 16'(side);
  end
endmodule

// [dv/testbench.sv]
// Self-checking bench for the thermal overcurrent element.
// Assumes the front-end model drives the measurement bus.
module testbench
  import thermal_oc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TL = 20;
  typedef struct {
    logic [15:0] ctrl;
    logic [15:0] tchar;
    logic [15:0] amps;
    logic neg;
    int ticks;
  } row_t;
  typedef struct {
    logic [15:0] ctrl;
    logic [15:0] vpp;
    logic [15:0] vpg;
    logic [15:0] pk;
    logic [15:0] amps;
    logic exp;
  } vr_t;
  // Curve, K, rating, clamp, restraint and sequence cases.
  row_t rows[11] = '{
    '{16'h0030, 16'h0002, 16'h0200, 1'b0, 10},
    '{16'h0034, 16'h0002, 16'h0300, 1'b0, 10},
    '{16'h003c, 16'h0001, 16'h0300, 1'b0, 5},
    '{16'h0038, 16'h0001, 16'h0300, 1'b0, 5},
    '{16'h0036, 16'h0004, 16'h0200, 1'b0, 10},
    '{16'h0037, 16'h0004, 16'h0a80, 1'b0, 10},
    '{16'h003c, 16'h0064, 16'h5000, 1'b0, 3},
    '{16'h0070, 16'h0002, 16'h0200, 1'b0, 10},
    '{16'h0230, 16'h0002, 16'h0200, 1'b1, 10},
    '{16'h0234, 16'h0002, 16'h0333, 1'b1, 10},
    '{16'h0230, 16'h0002, 16'h0200, 1'b0, 0}};
  // Voltage-restrained pickup cases.
  vr_t vr[10] = '{
    '{16'h0040, 16'h0000, 16'h0000, 16'h0400, 16'h0080, 1'b1},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0400, 16'h0080, 1'b0},
    '{16'h0040, 16'h03e8, 16'h0000, 16'h0400, 16'h0080, 1'b0},
    '{16'h0040, 16'h0271, 16'h0000, 16'h0400, 16'h00b3, 1'b1},
    '{16'h0040, 16'h0271, 16'h0000, 16'h0400, 16'h008d, 1'b0},
    '{16'h00c0, 16'h03e8, 16'h0000, 16'h0400, 16'h00b3, 1'b0},
    '{16'h01c0, 16'h0000, 16'h0258, 16'h0400, 16'h00b3, 1'b0},
    '{16'h0140, 16'h0000, 16'h0258, 16'h0400, 16'h00b3, 1'b1},
    '{16'h0040, 16'h0000, 16'h0000, 16'h0015, 16'h0004, 1'b0},
    '{16'h0040, 16'h0000, 16'h0000, 16'h0015, 16'h0007, 1'b1}};
  logic [7:0] ra[6] = '{OFS_CTRL, OFS_PICKUP, OFS_TCHAR, OFS_TRESET,
    OFS_VTSEC, 8'h20};
  logic [31:0] rv[6] = '{32'h0, 32'h400, 32'h64, 32'h0, 32'h3e8, 32'h0};
  int keep[3] = '{40, 7, 0};
  int clr[3] = '{50, 13, 2};
  logic [15:0] rmode[3] = '{16'h0000, 16'h0010, 16'h0030};
  logic clk = 1'b0;
  logic rst = 1'b1;
  reg_req_t req = '0;
  logic [31:0] rdata;
  meas_t meas;
  logic mcb = 1'b0;
  logic trip;
  logic pick;
  logic [15:0] amps = 16'h0;
  logic [15:0] vpp = 16'h03e8;
  logic [15:0] vpg = 16'h0;
  logic neg = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;

  thermal_curve_overcurrent_timing #(.TICK_LEN(TL)) u_dut (
    .CLK_I(clk), .RESET_I(rst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
    .MEAS_I(meas), .MCB_TRIP_I(mcb), .TRIP_O(trip), .PICKUP_O(pick));
  meas_front_end u_fe (.clk_i(clk), .amps_i(amps), .neg_i(neg),
    .vpp_i(vpp), .vpg_i(vpg), .meas_o(meas));

  always #20 clk = ~clk;

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      $display("MISMATCH run length expected done seen hang");
      finish_test();
    end
  end

  task automatic cmp(input logic [31:0] s, input logic [31:0] e,
    input string what);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e, input string what);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    cmp(rdata & m, e, what);
  endtask

  task automatic restart(input logic [15:0] ctrl, input logic [15:0] tc);
    @(posedge clk);
    rst <= 1'b1;
    amps <= 16'h0;
    mcb <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(OFS_CTRL, {16'h0, ctrl});
    wr(OFS_TCHAR, {16'h0, tc});
  endtask

  // Counts cycles until trip; zero ticks means no trip may come.
  task automatic wait_trip(input int n, input string what);
    int c;
    int lim;
    c = 0;
    lim = (n == 0) ? 20 * TL : (n + 1) * TL + 6;
    while (trip !== 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
    checks_done++;
    if (n == 0 ? c < lim : (c <= (n - 1) * TL || c > n * TL + 6)) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0d ticks seen %0d cycles", what, n, c);
    end
  endtask

  task automatic drop(input int n);
    @(posedge clk);
    amps <= 16'h0;
    repeat (n * TL) @(posedge clk);
    @(negedge clk);
    cmp({31'h0, trip}, 32'h0, "trip while low");
    @(posedge clk);
    amps <= 16'h0200;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(ra[i], 32'hffffffff, rv[i], "register reset");
    @(negedge clk);
    cmp(rdata, 32'h0, "read data idle");
    wr(OFS_STATUS, 32'hffffffff);
    rd(OFS_STATUS, 32'h1f, 32'h0, "status read only");
    wr(OFS_PICKUP, 32'h5);
    rd(OFS_PICKUP, 32'hffff, 32'h15, "pickup floor");
    $display("test registers done");
    for (int i = 0; i < 11; i++) begin
      restart(rows[i].ctrl, rows[i].tchar);
      @(posedge clk);
      neg <= rows[i].neg;
      amps <= rows[i].amps;
      wait_trip(rows[i].ticks, "trip time");
      $display("test row %0d done", i);
    end
    neg <= 1'b0;
    restart(16'h0, 16'h0064);
    for (int i = 0; i < 10; i++) begin
      wr(OFS_CTRL, {16'h0, vr[i].ctrl});
      wr(OFS_PICKUP, {16'h0, vr[i].pk});
      @(posedge clk);
      vpp <= vr[i].vpp;
      vpg <= vr[i].vpg;
      amps <= vr[i].amps;
      repeat (64) @(posedge clk);
      @(negedge clk);
      cmp({31'h0, pick}, {31'h0, vr[i].exp}, "pickup");
    end
    $display("test restraint done");
    for (int m = 0; m < 3; m++) begin
      restart(rmode[m], 16'h0001);
      wr(OFS_TRESET, 32'ha);
      @(posedge clk);
      amps <= 16'h0200;
      wait_trip(5, "first trip");
      if (keep[m] > 0) begin
        drop(keep[m]);
        wait_trip(1, "kept time");
      end
      drop(clr[m]);
      wait_trip(5, "cleared time");
      $display("test reset mode %0d done", m);
    end
    restart(16'h0470, 16'h0001);
    @(posedge clk);
    mcb <= 1'b1;
    amps <= 16'h0200;
    wait_trip(0, "blocked trip");
    rd(OFS_STATUS, 32'h10, 32'h10, "blocked flag");
    @(posedge clk);
    mcb <= 1'b0;
    wait_trip(5, "unblocked trip");
    $display("test blocking done");
    finish_test();
  end
endmodule
